// >>> rtl/bps_pkg.sv
/*
 * package for the buffered parallel slave port: register offsets, field
 * positions, reset values and mode encodings.
 * assumes a 32-bit software register port with byte addresses.
 */
package bps_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int BPS_AW = 8;
   localparam logic [7:0] BPS_CTRL_OFS = 8'h00;
   localparam logic [7:0] BPS_MODE_OFS = 8'h04;
   localparam logic [7:0] BPS_STAT_OFS = 8'h08;
   localparam logic [7:0] BPS_IN_OFS = 8'h0c;
   localparam logic [7:0] BPS_OUT_OFS = 8'h10;

   // ****************************************
   // field positions
   // ****************************************
   localparam int BPS_CTRL_ON_BIT = 15;
   localparam int BPS_CTRL_CS_POL_BIT = 3;
   localparam int BPS_CTRL_WR_POL_BIT = 1;
   localparam int BPS_CTRL_RD_POL_BIT = 0;
   localparam int BPS_MODE_PORT_LSB = 8;
   localparam int BPS_MODE_INCM_LSB = 11;
   localparam int BPS_MODE_IRQM_LSB = 13;
   localparam int BPS_STAT_IRQF_BIT = 31;
   localparam int BPS_STAT_IBF_BIT = 15;
   localparam int BPS_STAT_IN_OVERFLOW_BIT = 14;
   localparam int BPS_STAT_IN_BUF_FULL_N_LSB = 8;
   localparam int BPS_STAT_OBE_BIT = 7;
   localparam int BPS_STAT_OUT_UNDERFLOW_BIT = 6;
   localparam int BPS_STAT_OUT_BUF_EMPTY_N_LSB = 0;

   // ****************************************
   // reset values and encodings
   // ****************************************
   localparam logic [3:0] BPS_OB_EMPTY_RST = 4'hf;
   localparam logic [3:0] BPS_IB_FULL_RST = 4'h0;
   localparam logic [31:0] BPS_WORD_RST = 32'h0000_0000;
   localparam logic [1:0] BPS_FIELD_RST = 2'h0;
   localparam logic [1:0] BPS_PORT_SLAVE = 2'h0;
   localparam logic [1:0] BPS_PORT_ADDR = 2'h1;
   localparam logic [1:0] BPS_INCM_BUF = 2'h3;
   localparam logic [1:0] BPS_IRQM_EVERY = 2'h1;
   localparam logic [1:0] BPS_IRQM_BUF3 = 2'h2;
   localparam logic [1:0] BPS_LAST_BUF = 2'h3;
   localparam int BPS_PIN_W = 13;

   typedef enum logic [1:0] {
      BPS_OFF = 2'b00,
      BPS_LEGACY = 2'b01,
      BPS_BUFFERED = 2'b10,
      BPS_ADDRESSED = 2'b11
   } bps_mode_t;

endpackage

// >>> rtl/bps_slave_port.sv
/*
 * buffered parallel slave port: 8-bit slave for an external asynchronous
 * master, legacy, four-deep buffered and addressable buffered modes.
 * assumes one 20 MHz clock, a synchronous active-high reset and a simple
 * software register port with read data one cycle after the read strobe.
 */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps

module bps_slave_port #(
   parameter bit PERSISTENT_IRQ = 1'b0
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // software register port
   input wire logic [bps_pkg::BPS_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // parallel pins
   input wire logic chip_sel_in,
   input wire logic read_strobe_in,
   input wire logic write_strobe_in,
   input wire logic [1:0] slave_addr_in,
   input wire logic [7:0] parallel_data_bus_in,
   output logic [7:0] parallel_data_bus_out,
   output logic parallel_data_bus_oe,
   // interrupt flag towards the interrupt controller
   output logic port_interrupt_flag
);
   import bps_pkg::*;

   // ****************************************
   // control registers
   // ****************************************
   logic on_ff, on_q_ff, cs_pol_ff, wr_pol_ff, rd_pol_ff;
   logic [1:0] port_mode_ff, increment_sel_ff, irq_mode_sel_ff;
   logic ctrl_wr, mode_wr, stat_wr, in_rd, out_wr, in_wr;

   assign ctrl_wr = reg_wr && (reg_addr == BPS_CTRL_OFS);
   assign mode_wr = reg_wr && (reg_addr == BPS_MODE_OFS);
   assign stat_wr = reg_wr && (reg_addr == BPS_STAT_OFS);
   assign in_wr = reg_wr && (reg_addr == BPS_IN_OFS);
   assign out_wr = reg_wr && (reg_addr == BPS_OUT_OFS);
   assign in_rd = reg_rd && (reg_addr == BPS_IN_OFS);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         on_ff <= 1'b0;
         cs_pol_ff <= 1'b0;
         wr_pol_ff <= 1'b0;
         rd_pol_ff <= 1'b0;
      end else if (ctrl_wr) begin
         on_ff <= reg_wdata[BPS_CTRL_ON_BIT];
         cs_pol_ff <= reg_wdata[BPS_CTRL_CS_POL_BIT];
         wr_pol_ff <= reg_wdata[BPS_CTRL_WR_POL_BIT];
         rd_pol_ff <= reg_wdata[BPS_CTRL_RD_POL_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         port_mode_ff <= BPS_FIELD_RST;
         increment_sel_ff <= BPS_FIELD_RST;
         irq_mode_sel_ff <= BPS_FIELD_RST;
      end else if (mode_wr) begin
         port_mode_ff <= reg_wdata[BPS_MODE_PORT_LSB +: 2];
         increment_sel_ff <= reg_wdata[BPS_MODE_INCM_LSB +: 2];
         irq_mode_sel_ff <= reg_wdata[BPS_MODE_IRQM_LSB +: 2];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         on_q_ff <= 1'b0;
      end else begin
         on_q_ff <= on_ff;
      end
   end

   // ****************************************
   // mode decode
   // ****************************************
   bps_mode_t cur_mode;
   logic clr_all;

   always_comb begin
      cur_mode = BPS_OFF;
      if (on_ff) begin
         case (port_mode_ff)
            BPS_PORT_SLAVE: begin
               cur_mode = (increment_sel_ff == BPS_INCM_BUF) ? BPS_BUFFERED : BPS_LEGACY;
            end
            BPS_PORT_ADDR: begin
               cur_mode = BPS_ADDRESSED;
            end
            default: begin
               cur_mode = BPS_OFF;
            end
         endcase
      end
   end

   assign clr_all = on_ff && !on_q_ff;

   // ****************************************
   // pin synchroniser
   // ****************************************
   // data and address ride the same two flops as the strobes, so they line
   // up with the strobe edges the master gives them setup against
   logic [BPS_PIN_W-1:0] pin_raw, pin_s1_ff, pin_s2_ff;

   assign pin_raw = {parallel_data_bus_in, slave_addr_in, chip_sel_in, read_strobe_in, write_strobe_in};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
      end else begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
      end
   end

   logic cs_act, rd_lvl, wr_lvl, rd_lvl_ff, wr_lvl_ff;
   logic [1:0] addr_s;
   logic [7:0] data_s, wr_hold_ff, wr_byte;

   assign cs_act = pin_s2_ff[2] ~^ cs_pol_ff;
   assign rd_lvl = cs_act && (pin_s2_ff[1] ~^ rd_pol_ff);
   assign wr_lvl = cs_act && (pin_s2_ff[0] ~^ wr_pol_ff);
   assign addr_s = pin_s2_ff[4:3];
   assign data_s = pin_s2_ff[12:5];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_lvl_ff <= 1'b0;
         wr_lvl_ff <= 1'b0;
      end else begin
         rd_lvl_ff <= rd_lvl;
         wr_lvl_ff <= wr_lvl;
      end
   end

   // byte held from the strobe, since a trailing-edge capture comes after
   // the master may already have released the bus
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_hold_ff <= 8'h00;
      end else if (wr_lvl) begin
         wr_hold_ff <= data_s;
      end
   end

   assign wr_byte = wr_lvl ? data_s : wr_hold_ff;

   // ****************************************
   // strobe events
   // ****************************************
   logic rd_hit, wr_hit, rd_unf, wr_ovf, irq_ev;
   logic [1:0] rptr_ff, wptr_ff, rd_sel, wr_sel;
   logic [3:0] ob_empty_ff, ib_full_ff;
   logic [31:0] in_word_ff, out_word_ff;

   // no events in the enable cycle: the edge flops still hold levels seen
   // under the old polarity, which would fake a leading or trailing edge
   assign rd_hit = rd_lvl && !rd_lvl_ff && (cur_mode != BPS_OFF) && !clr_all;
   assign wr_hit = (PERSISTENT_IRQ ? (!wr_lvl && wr_lvl_ff) : (wr_lvl && !wr_lvl_ff)) && (cur_mode != BPS_OFF)
      && !clr_all;

   always_comb begin
      case (cur_mode)
         BPS_BUFFERED: begin
            rd_sel = rptr_ff;
            wr_sel = wptr_ff;
         end
         BPS_ADDRESSED: begin
            rd_sel = addr_s;
            wr_sel = addr_s;
         end
         default: begin
            rd_sel = 2'h0;
            wr_sel = 2'h0;
         end
      endcase
   end

   assign rd_unf = rd_hit && ob_empty_ff[rd_sel];
   assign wr_ovf = wr_hit && ib_full_ff[wr_sel];

   always_comb begin
      irq_ev = 1'b0;
      if (cur_mode == BPS_LEGACY) begin
         irq_ev = rd_hit || wr_hit;
      end else if (irq_mode_sel_ff == BPS_IRQM_EVERY) begin
         irq_ev = rd_hit || wr_hit;
      end else if (irq_mode_sel_ff == BPS_IRQM_BUF3) begin
         irq_ev = (rd_hit && rd_sel == BPS_LAST_BUF) || (wr_hit && wr_sel == BPS_LAST_BUF);
      end
   end

   // ****************************************
   // pointers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst || clr_all) begin
         rptr_ff <= 2'h0;
      end else if (rd_hit && cur_mode == BPS_BUFFERED) begin
         rptr_ff <= rptr_ff + 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || clr_all) begin
         wptr_ff <= 2'h0;
      end else if (wr_hit && cur_mode == BPS_BUFFERED) begin
         wptr_ff <= wptr_ff + 2'h1;
      end
   end

   // ****************************************
   // per-buffer flags and input bytes
   // ****************************************
   // hardware sets win over a same-cycle software clear
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_buf
         always_ff @(posedge clk_sys) begin
            if (rst || clr_all) begin
               ob_empty_ff[b] <= BPS_OB_EMPTY_RST[b];
            end else if (rd_hit && rd_sel == b) begin
               ob_empty_ff[b] <= 1'b1;
            end else if (out_wr) begin
               ob_empty_ff[b] <= 1'b0;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst || clr_all) begin
               ib_full_ff[b] <= BPS_IB_FULL_RST[b];
            end else if (wr_hit && wr_sel == b) begin
               ib_full_ff[b] <= 1'b1;
            end else if (in_rd) begin
               ib_full_ff[b] <= 1'b0;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst) begin
               in_word_ff[b*8 +: 8] <= 8'h00;
            end else if (wr_hit && wr_sel == b && !ib_full_ff[b]) begin
               in_word_ff[b*8 +: 8] <= wr_byte;
            end else if (in_wr) begin
               in_word_ff[b*8 +: 8] <= reg_wdata[b*8 +: 8];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_word_ff <= BPS_WORD_RST;
      end else if (out_wr) begin
         out_word_ff <= reg_wdata;
      end
   end

   // ****************************************
   // sticky status flags
   // ****************************************
   logic out_underflow_ff, in_overflow_ff, irq_ff;

   always_ff @(posedge clk_sys) begin
      if (rst || clr_all) begin
         out_underflow_ff <= 1'b0;
      end else if (rd_unf) begin
         out_underflow_ff <= 1'b1;
      end else if (stat_wr && reg_wdata[BPS_STAT_OUT_UNDERFLOW_BIT]) begin
         out_underflow_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || clr_all) begin
         in_overflow_ff <= 1'b0;
      end else if (wr_ovf) begin
         in_overflow_ff <= 1'b1;
      end else if (stat_wr && reg_wdata[BPS_STAT_IN_OVERFLOW_BIT]) begin
         in_overflow_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_ff <= 1'b0;
      end else if (irq_ev) begin
         irq_ff <= 1'b1;
      end else if (stat_wr && reg_wdata[BPS_STAT_IRQF_BIT]) begin
         irq_ff <= 1'b0;
      end
   end

   assign port_interrupt_flag = irq_ff;

   // ****************************************
   // parallel data output
   // ****************************************
   // the bus turns on two to three clocks after the strobe; masters must allow for
   // that synchroniser delay before sampling
   logic [7:0] dout_ff;
   logic oe_ff;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dout_ff <= 8'h00;
      end else if (rd_hit && !rd_unf) begin
         dout_ff <= out_word_ff[{rd_sel, 3'b000} +: 8];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= rd_lvl && (cur_mode != BPS_OFF);
      end
   end

   assign parallel_data_bus_out = dout_ff;
   assign parallel_data_bus_oe = oe_ff;

   // ****************************************
   // register read
   // ****************************************
   logic [31:0] nxt_rdata, stat_word, rdata_ff;

   always_comb begin
      stat_word = 32'h0000_0000;
      stat_word[BPS_STAT_IRQF_BIT] = irq_ff;
      stat_word[BPS_STAT_IBF_BIT] = &ib_full_ff;
      stat_word[BPS_STAT_IN_OVERFLOW_BIT] = in_overflow_ff;
      stat_word[BPS_STAT_IN_BUF_FULL_N_LSB +: 4] = ib_full_ff;
      stat_word[BPS_STAT_OBE_BIT] = &ob_empty_ff;
      stat_word[BPS_STAT_OUT_UNDERFLOW_BIT] = out_underflow_ff;
      stat_word[BPS_STAT_OUT_BUF_EMPTY_N_LSB +: 4] = ob_empty_ff;
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (reg_addr)
         BPS_CTRL_OFS: begin
            nxt_rdata[BPS_CTRL_ON_BIT] = on_ff;
            nxt_rdata[BPS_CTRL_CS_POL_BIT] = cs_pol_ff;
            nxt_rdata[BPS_CTRL_WR_POL_BIT] = wr_pol_ff;
            nxt_rdata[BPS_CTRL_RD_POL_BIT] = rd_pol_ff;
         end
         BPS_MODE_OFS: begin
            nxt_rdata[BPS_MODE_PORT_LSB +: 2] = port_mode_ff;
            nxt_rdata[BPS_MODE_INCM_LSB +: 2] = increment_sel_ff;
            nxt_rdata[BPS_MODE_IRQM_LSB +: 2] = irq_mode_sel_ff;
         end
         BPS_STAT_OFS: begin
            nxt_rdata = stat_word;
         end
         BPS_IN_OFS: begin
            nxt_rdata = in_word_ff;
         end
         BPS_OUT_OFS: begin
            nxt_rdata = out_word_ff;
         end
         default: begin
            nxt_rdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_ff;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic rd_pin_act;
   assign rd_pin_act = (chip_sel_in ~^ cs_pol_ff) && (read_strobe_in ~^ rd_pol_ff) && (cur_mode != BPS_OFF);

   sequence s_rd_pin_rise;
      $rose(rd_pin_act) && $stable(cur_mode);
   endsequence

   // pin first sampled high at one edge, event two edges later; the pin's
   // phase before that sampling edge makes up the third clock
   sequence s_rd_event_late;
      ##1 rd_hit;
   endsequence

   sync_latency_a: assert property (s_rd_pin_rise ##1 $stable(rd_pin_act) |-> s_rd_event_late)
      else $error("strobe not seen two to three clocks after pin");
   legacy_drive_a: assert property (rd_hit && cur_mode == BPS_LEGACY && !ob_empty_ff[0]
      |=> dout_ff == $past(out_word_ff[7:0]) && ob_empty_ff[0])
      else $error("legacy read byte or empty flag wrong");
   empty_hold_a: assert property (ob_empty_ff[0] && !out_wr && !clr_all |=> ob_empty_ff[0])
      else $error("empty flag dropped without software write");
   underflow_a: assert property (rd_hit && ob_empty_ff[rd_sel] |=> out_underflow_ff && $stable(dout_ff))
      else $error("underflow not flagged or byte changed");
   legacy_irq_a: assert property (cur_mode == BPS_LEGACY && (rd_hit || wr_hit) |=> port_interrupt_flag)
      else $error("legacy strobe did not raise interrupt flag");
   buf3_irq_a: assert property (cur_mode == BPS_BUFFERED && irq_mode_sel_ff == BPS_IRQM_BUF3 && !irq_ff
      && !rd_hit && wr_hit && wptr_ff != BPS_LAST_BUF |=> !port_interrupt_flag)
      else $error("interrupt raised for non-last buffer");
   wptr_step_a: assert property (wr_hit && cur_mode == BPS_BUFFERED |=> wptr_ff == $past(wptr_ff) + 2'h1)
      else $error("write pointer did not step");
   overflow_a: assert property (wr_hit && ib_full_ff[wr_sel] |=> in_overflow_ff && $stable(in_word_ff))
      else $error("overflow not flagged or byte stored");
   all_empty_a: assert property (reg_rd && reg_addr == BPS_STAT_OFS
      |=> reg_rdata[BPS_STAT_OBE_BIT] == (&$past(ob_empty_ff)))
      else $error("all-empty status wrong");
   all_full_a: assert property (reg_rd && reg_addr == BPS_STAT_OFS
      |=> reg_rdata[BPS_STAT_IBF_BIT] == (&$past(ib_full_ff)))
      else $error("all-full status wrong");
   enable_clear_a: assert property ($rose(on_ff) |=> ob_empty_ff == BPS_OB_EMPTY_RST
      && ib_full_ff == BPS_IB_FULL_RST && rptr_ff == 2'h0 && wptr_ff == 2'h0)
      else $error("enable did not reset buffer state");
   addr_read_a: assert property (rd_hit && cur_mode == BPS_ADDRESSED |=> ob_empty_ff[$past(addr_s)])
      else $error("addressed read did not set empty flag");

endmodule

// >>> tb/bps_master_model.sv
/*
 * external bus master model: drives chip select, strobes, address and data.
 * assumes the bench calls xfer; pins change just after a rising edge.
 */
`timescale 1ns/1ps

module bps_master_model (
   // clock and device side
   input wire logic clk_sys,
   input wire logic act_low,
   input wire logic [7:0] dev_out,
   input wire logic dev_oe,
   // pins
   output logic chip_sel_in,
   output logic read_strobe_in,
   output logic write_strobe_in,
   output logic [1:0] slave_addr_in,
   output logic [7:0] bus_in
);
   logic cs_raw = 1'b0;
   logic rd_raw = 1'b0;
   logic wr_raw = 1'b0;
   logic drv_on = 1'b0;
   logic [7:0] drv_ff = 8'h00;
   logic [7:0] last_ff = 8'h00;
   initial slave_addr_in = 2'h0;
   assign chip_sel_in = cs_raw ^ act_low;
   assign read_strobe_in = rd_raw ^ act_low;
   assign write_strobe_in = wr_raw ^ act_low;
   // released bus has no pull: it toggles so a stale byte never reads back
   assign bus_in = dev_oe ? dev_out : (drv_on ? drv_ff : ~last_ff);
   always @(posedge clk_sys) last_ff <= bus_in;

   // strobe held 6 clocks, idle at least 5: the device needs 2 of each
   task automatic xfer(input logic wr, input logic [1:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      slave_addr_in <= a;
      drv_ff <= d;
      drv_on <= wr;
      cs_raw <= 1'b1;
      rd_raw <= ~wr;
      wr_raw <= wr;
      repeat (5) @(posedge clk_sys);
      #1 q = bus_in;
      @(posedge clk_sys);
      cs_raw <= 1'b0;
      rd_raw <= 1'b0;
      wr_raw <= 1'b0;
      drv_on <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule

// >>> tb/bps_slave_port_tb.sv
/*
 * self-checking bench for the parallel slave port, one task per scenario.
 * assumes the master model drives the pins and the register map of bps_pkg.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module bps_slave_port_tb;
   import bps_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic act_low = 1'b0;
   logic [31:0] reg_rdata, rdata_p;
   logic cs, rd, wr, oe, irq, irq_p;
   logic [1:0] sa;
   logic [7:0] din, dout;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   always #25 clk_sys = ~clk_sys;

   bps_slave_port i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_sel_in(cs), .read_strobe_in(rd),
      .write_strobe_in(wr), .slave_addr_in(sa), .parallel_data_bus_in(din), .parallel_data_bus_out(dout),
      .parallel_data_bus_oe(oe), .port_interrupt_flag(irq));
   // trailing-edge variant listens on the same pins and register port
   bps_slave_port #(.PERSISTENT_IRQ(1'b1)) i_dut_trail (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_p), .chip_sel_in(cs),
      .read_strobe_in(rd), .write_strobe_in(wr), .slave_addr_in(sa), .parallel_data_bus_in(din),
      .parallel_data_bus_out(), .parallel_data_bus_oe(), .port_interrupt_flag(irq_p));
   bps_master_model i_mst (.clk_sys(clk_sys), .act_low(act_low), .dev_out(dout), .dev_oe(oe),
      .chip_sel_in(cs), .read_strobe_in(rd), .write_strobe_in(wr), .slave_addr_in(sa), .bus_in(din));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic rw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rr(input logic [7:0] a, output logic [31:0] q);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic stat(input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      rr(BPS_STAT_OFS, q);
      `CHK("status", e, q & m)
   endtask
   task automatic pin_rd(input logic [1:0] a, input logic [7:0] e);
      logic [7:0] q;
      i_mst.xfer(1'b0, a, 8'h00, q);
      `CHK("pin byte", e, q)
   endtask
   task automatic pin_wr(input logic [1:0] a, input logic [7:0] d);
      logic [7:0] q;
      i_mst.xfer(1'b1, a, d, q);
   endtask
   // off, mode, on, then clear the sticky interrupt flag
   task automatic cfg(input logic [31:0] c, input logic [31:0] m);
      rw(BPS_CTRL_OFS, 32'h0);
      rw(BPS_MODE_OFS, m);
      rw(BPS_CTRL_OFS, c);
      rw(BPS_STAT_OFS, 32'h8000_0000);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_legacy();
      logic [31:0] q;
      stat(32'hffff_ffff, 32'h0000_008f);
      cfg(32'h0000_800b, 32'h0);
      rw(BPS_OUT_OFS, 32'h0000_00a5);
      pin_rd(2'h0, 8'ha5);
      stat(32'h8000_004f, 32'h8000_0001);
      pin_rd(2'h0, 8'ha5);
      stat(32'h0000_004f, 32'h0000_0041);
      rw(BPS_STAT_OFS, 32'h8000_0000);
      fork
         pin_wr(2'h0, 8'h3c);
         begin
            repeat (5) @(posedge clk_sys);
            `CHK("irq lead", 1'b1, irq)
            `CHK("irq trail early", 1'b0, irq_p)
         end
      join
      `CHK("irq pin", 1'b1, irq)
      `CHK("irq trail", 1'b1, irq_p)
      pin_wr(2'h0, 8'h99);
      stat(32'h0000_4100, 32'h0000_4100);
      rr(BPS_IN_OFS, q);
      `CHK("in byte", 8'h3c, q[7:0])
      `CHK("trail byte", 8'h3c, rdata_p[7:0])
      rr(8'h20, q);
      `CHK("unmapped", 32'h0, q)
   endtask
   task automatic t_buf();
      logic [31:0] q;
      cfg(32'h0000_800b, 32'h0000_3800);
      rw(BPS_OUT_OFS, 32'h4433_2211);
      for (int i = 0; i < 4; i++) begin
         pin_rd(2'h0, 8'(8'h11 * (i + 1)));
      end
      stat(32'h0000_00cf, 32'h0000_008f);
      pin_rd(2'h0, 8'h44);
      stat(32'h8000_0040, 32'h8000_0040);
      for (int i = 0; i < 4; i++) begin
         pin_wr(2'h0, 8'(8'ha0 + i));
      end
      stat(32'h0000_cf00, 32'h0000_8f00);
      pin_wr(2'h0, 8'h55);
      stat(32'h0000_4000, 32'h0000_4000);
      rr(BPS_IN_OFS, q);
      `CHK("in word", 32'ha3a2_a1a0, q)
      stat(32'h0000_0f00, 32'h0);
   endtask
   task automatic t_irq_buf3();
      cfg(32'h0000_800b, 32'h0000_5800);
      stat(32'h0000_cfcf, 32'h0000_008f);
      for (int i = 0; i < 3; i++) begin
         pin_wr(2'h0, 8'(i));
      end
      `CHK("irq early", 1'b0, irq)
      pin_wr(2'h0, 8'h03);
      `CHK("irq buf3", 1'b1, irq)
   endtask
   task automatic t_addr();
      logic [31:0] q;
      cfg(32'h0000_800b, 32'h0000_0100);
      rw(BPS_OUT_OFS, 32'hddcc_bbaa);
      pin_rd(2'h2, 8'hcc);
      stat(32'h0000_004f, 32'h0000_0004);
      pin_rd(2'h2, 8'hcc);
      stat(32'h0000_0040, 32'h0000_0040);
      pin_wr(2'h3, 8'h77);
      pin_wr(2'h3, 8'h78);
      stat(32'h0000_4f00, 32'h0000_4800);
      rr(BPS_IN_OFS, q);
      `CHK("addr byte", 8'h77, q[31:24])
   endtask
   task automatic t_pol();
      rw(BPS_CTRL_OFS, 32'h0);
      @(posedge clk_sys);
      act_low <= 1'b1;
      cfg(32'h0000_8000, 32'h0);
      rw(BPS_OUT_OFS, 32'h0000_005a);
      pin_rd(2'h0, 8'h5a);
   endtask

   task automatic results();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // whole run is well under 3000 clocks
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_legacy();
      t_buf();
      t_irq_buf3();
      t_addr();
      t_pol();
      results();
   end
endmodule
